/* File: hw/pattern_match_slice_condition.sv */
// Purpose: Match condition logic for bit slices 5 and 6 of a pattern match engine.
// Assumes: Inputs synchronous to sys_clk; register port with read data one cycle later.
// Notes: Interrupt status bits are set by slice match rising edges.
// How it works
// - Slice 5 condition at bits 25:23, reset zero.
// - Slice 6 condition at bits 28:26, same encoding.
// - Code 0 always matches.
// - Code 1 sticky rising edge match.
// - Code 2 sticky falling edge match.
// - Code 3 sticky either edge match.
// - Only config or source writes clear stickies.
// - Code 4 matches on high input.
// - Code 5 matches on low input.
// - Code 6 never matches.
// - Code 7 non-sticky edge event match.
// - Event match lasts exactly one cycle.
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`include "slice_cond_regs.svh"

module pattern_match_slice_condition #(
  parameter int NUM_INPUTS = 8
) (
  input wire logic sys_clk, // System clock, 100 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic [7:0] reg_addr, // Register byte address.
  input wire logic [31:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  output logic [31:0] reg_rdata, // Read data, valid the cycle after the strobe.
  input wire logic [NUM_INPUTS-1:0] pin_in, // Candidate slice inputs.
  output logic slice5_match, // Slice 5 match contribution.
  output logic slice6_match, // Slice 6 match contribution.
  output logic irq // Level interrupt.
);

  // The three-bit source field can address at most eight inputs.
  if (NUM_INPUTS < 1 || NUM_INPUTS > 8) begin : g_bad_width
    $error("NUM_INPUTS must be between 1 and 8.");
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [31:0] cfg_q;
  logic [31:0] src_q;
  logic [1:0] irq_status_q;
  logic [1:0] irq_mask_q;

  wire wr_cfg = reg_wr && (reg_addr == `REG_COND_CFG);
  wire wr_src = reg_wr && (reg_addr == `REG_SRC_SEL);
  wire wr_sts = reg_wr && (reg_addr == `REG_IRQ_STATUS);
  wire wr_msk = reg_wr && (reg_addr == `REG_IRQ_MASK);
  // Any write to either register clears the sticky edge flags of both slices.
  wire sticky_clr = wr_cfg || wr_src;

  wire [2:0] slice5_condition = cfg_q[`SLICE5_COND_LSB +: 3];
  wire [2:0] slice6_condition = cfg_q[`SLICE6_COND_LSB +: 3];
  wire [2:0] sel5 = src_q[3*5 +: 3];
  wire [2:0] sel6 = src_q[3*6 +: 3];

  function automatic logic pick(input logic [NUM_INPUTS-1:0] v, input logic [2:0] s);
    pick = (32'(s) < NUM_INPUTS) ? v[s] : 1'b0;
  endfunction

  // --------------------------------------------------------------------------
  // Sampling and edge detection
  // --------------------------------------------------------------------------
  logic in5_q, in6_q, prev5_q, prev6_q;
  logic rise5_q, fall5_q, rise6_q, fall6_q;
  logic ev5_q, ev6_q;

  wire in5_d = pick(pin_in, sel5);
  wire in6_d = pick(pin_in, sel6);
  wire r5 = in5_q && !prev5_q;
  wire f5 = !in5_q && prev5_q;
  wire r6 = in6_q && !prev6_q;
  wire f6 = !in6_q && prev6_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      in5_q <= 1'b0;
      in6_q <= 1'b0;
      prev5_q <= 1'b0;
      prev6_q <= 1'b0;
    end else begin
      in5_q <= in5_d;
      in6_q <= in6_d;
      prev5_q <= in5_q;
      prev6_q <= in6_q;
    end
  end

  // A clearing write and a fresh edge in the same cycle: the set wins, so no
  // input activity is ever lost to a register access.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rise5_q <= 1'b0;
      fall5_q <= 1'b0;
      rise6_q <= 1'b0;
      fall6_q <= 1'b0;
    end else begin
      rise5_q <= (rise5_q && !sticky_clr) || r5;
      fall5_q <= (fall5_q && !sticky_clr) || f5;
      rise6_q <= (rise6_q && !sticky_clr) || r6;
      fall6_q <= (fall6_q && !sticky_clr) || f6;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ev5_q <= 1'b0;
      ev6_q <= 1'b0;
    end else begin
      ev5_q <= r5 | f5;
      ev6_q <= r6 | f6;
    end
  end

  // --------------------------------------------------------------------------
  // Condition evaluation
  // --------------------------------------------------------------------------
  function automatic logic eval(input logic [2:0] c, input logic lvl, input logic rs,
                                input logic fs, input logic ev);
    case (slice_cond_pkg::cond_e'(c))
      slice_cond_pkg::COND_HIGH: eval = 1'b1;
      slice_cond_pkg::COND_STICKY_RISE: eval = rs;
      slice_cond_pkg::COND_STICKY_FALL: eval = fs;
      slice_cond_pkg::COND_STICKY_ANY: eval = rs | fs;
      slice_cond_pkg::COND_LEVEL_HIGH: eval = lvl;
      slice_cond_pkg::COND_LEVEL_LOW: eval = !lvl;
      slice_cond_pkg::COND_ZERO: eval = 1'b0;
      slice_cond_pkg::COND_EVENT: eval = ev;
      default: eval = 1'b0;
    endcase
  endfunction

  wire m5_d = eval(slice5_condition, in5_q, rise5_q, fall5_q, ev5_q);
  wire m6_d = eval(slice6_condition, in6_q, rise6_q, fall6_q, ev6_q);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      slice5_match <= 1'b0;
      slice6_match <= 1'b0;
    end else begin
      slice5_match <= m5_d;
      slice6_match <= m6_d;
    end
  end

  // --------------------------------------------------------------------------
  // Register file and interrupts
  // --------------------------------------------------------------------------
  wire [1:0] match_rise = {m6_d & !slice6_match, m5_d & !slice5_match};
  wire [1:0] sts_clr = wr_sts ? reg_wdata[1:0] : 2'b00;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_q <= `COND_CFG_RESET;
      src_q <= `SRC_SEL_RESET;
      irq_status_q <= 2'h0;
      irq_mask_q <= 2'h0;
      irq <= 1'b0;
    end else begin
      if (wr_cfg) cfg_q <= reg_wdata;
      if (wr_src) src_q <= reg_wdata;
      if (wr_msk) irq_mask_q <= reg_wdata[1:0];
      // Set wins over a same-cycle write-one clear.
      irq_status_q <= (irq_status_q & ~sts_clr) | match_rise;
      irq <= |(((irq_status_q & ~sts_clr) | match_rise) & irq_mask_q);
    end
  end

  logic [31:0] rdata_d;
  always_comb begin
    rdata_d = 32'h00000000;
    case (reg_addr)
      `REG_COND_CFG: rdata_d = cfg_q;
      `REG_SRC_SEL: rdata_d = src_q;
      `REG_IRQ_STATUS: rdata_d = {30'h0, irq_status_q};
      `REG_IRQ_MASK: rdata_d = {30'h0, irq_mask_q};
      `REG_MATCH_STATE: rdata_d = {24'h0, ev6_q, fall6_q, rise6_q, ev5_q, fall5_q, rise5_q,
                                   slice6_match, slice5_match};
      default: rdata_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) reg_rdata <= 32'h00000000;
    else reg_rdata <= reg_rd ? rdata_d : 32'h00000000;
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  property p_reset_cfg;
    @(posedge sys_clk) rst |=> (cfg_q[28:23] == 6'h00);
  endproperty
  a_reset_cfg: assert property (p_reset_cfg)
    else $error("Condition fields not zero after reset.");

  property p_slice6_condition_field;
    @(posedge sys_clk) disable iff (rst) wr_cfg |=> (slice6_condition == $past(reg_wdata[28:26]));
  endproperty
  a_slice6_condition_field: assert property (p_slice6_condition_field)
    else $error("Slice 6 field not at 28:26.");

  property p_const_high;
    @(posedge sys_clk) disable iff (rst) (slice5_condition == 3'h0) |=> slice5_match;
  endproperty
  a_const_high: assert property (p_const_high)
    else $error("Constant high did not match.");

  property p_const_high6;
    @(posedge sys_clk) disable iff (rst) (slice6_condition == 3'h0) |=> slice6_match;
  endproperty
  a_const_high6: assert property (p_const_high6)
    else $error("Slice 6 constant high did not match.");

  property p_rise_sticky;
    @(posedge sys_clk) disable iff (rst)
      (slice5_condition == 3'h1 && r5 && !sticky_clr) ##1 !sticky_clr |=> slice5_match;
  endproperty
  a_rise_sticky: assert property (p_rise_sticky)
    else $error("Rising edge not held.");

  property p_fall_sticky;
    @(posedge sys_clk) disable iff (rst)
      (slice6_condition == 3'h2 && f6 && !sticky_clr) ##1 !sticky_clr |=> slice6_match;
  endproperty
  a_fall_sticky: assert property (p_fall_sticky)
    else $error("Falling edge not held.");

  property p_any_sticky;
    @(posedge sys_clk) disable iff (rst)
      (slice5_condition == 3'h3 && (r5 || f5) && !sticky_clr) ##1 !sticky_clr |=> slice5_match;
  endproperty
  a_any_sticky: assert property (p_any_sticky)
    else $error("Either edge not held.");

  // After a clearing write only an edge of that very cycle may remain.
  property p_clear;
    @(posedge sys_clk) disable iff (rst)
      sticky_clr |=> (rise5_q == $past(r5)) && (fall5_q == $past(f5)) &&
                     (rise6_q == $past(r6)) && (fall6_q == $past(f6));
  endproperty
  a_clear: assert property (p_clear)
    else $error("Sticky state not cleared by write.");

  property p_keep;
    @(posedge sys_clk) disable iff (rst) (rise5_q && !sticky_clr) |=> rise5_q;
  endproperty
  a_keep: assert property (p_keep)
    else $error("Sticky state lost without a write.");

  property p_level;
    @(posedge sys_clk) disable iff (rst)
      (slice6_condition == 3'h4 || slice6_condition == 3'h5) |=>
        (slice6_match == ($past(in6_q) ^ ($past(slice6_condition) == 3'h5)));
  endproperty
  a_level: assert property (p_level)
    else $error("Level condition wrong.");

  property p_level5;
    @(posedge sys_clk) disable iff (rst)
      (slice5_condition == 3'h4 || slice5_condition == 3'h5) |=>
        (slice5_match == ($past(in5_q) ^ ($past(slice5_condition) == 3'h5)));
  endproperty
  a_level5: assert property (p_level5)
    else $error("Slice 5 level condition wrong.");

  property p_zero;
    @(posedge sys_clk) disable iff (rst) (slice5_condition == 3'h6) |=> !slice5_match;
  endproperty
  a_zero: assert property (p_zero)
    else $error("Constant zero matched.");

  sequence s_edge5;
    (slice5_condition == 3'h7 && !wr_cfg) && (r5 || f5);
  endsequence
  property p_event;
    @(posedge sys_clk) disable iff (rst) s_edge5 ##1 (slice5_condition == 3'h7) |=> slice5_match;
  endproperty
  a_event: assert property (p_event)
    else $error("Edge event not reported.");

  sequence s_edge6;
    (slice6_condition == 3'h7 && !wr_cfg) && (r6 || f6);
  endsequence
  property p_event6;
    @(posedge sys_clk) disable iff (rst)
      s_edge6 ##1 (slice6_condition == 3'h7) |=> slice6_match;
  endproperty
  a_event6: assert property (p_event6)
    else $error("Slice 6 edge event not reported.");

  // A cycle without an edge leaves no event behind, so the pulse is one cycle.
  sequence s_quiet5;
    (slice5_condition == 3'h7) && !(r5 || f5);
  endsequence
  property p_event_once;
    @(posedge sys_clk) disable iff (rst)
      s_quiet5 ##1 (slice5_condition == 3'h7) |=> !slice5_match;
  endproperty
  a_event_once: assert property (p_event_once)
    else $error("Event held too long.");

  property p_sample;
    @(posedge sys_clk) disable iff (rst) 1'b1 |=> (prev5_q == $past(in5_q));
  endproperty
  a_sample: assert property (p_sample)
    else $error("Previous sample not kept.");

endmodule

/* File: hw/slice_cond_regs.svh */
// Purpose: Register offsets, field positions and reset values of the slice condition block.
// Assumes: Word-aligned byte addresses on the plain register port.
// Notes: Definitions only.
`ifndef SLICE_COND_REGS_SVH
`define SLICE_COND_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define REG_COND_CFG 8'h00
`define REG_SRC_SEL 8'h04
`define REG_IRQ_STATUS 8'h08
`define REG_IRQ_MASK 8'h0C
`define REG_MATCH_STATE 8'h10

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define SLICE5_COND_LSB 23
`define SLICE6_COND_LSB 26
`define COND_CFG_RESET 32'h00000000
`define SRC_SEL_RESET 32'h00000000
`define SRC_SEL_W 3

`endif

/* File: hw/slice_cond_pkg.sv */
// Purpose: Types shared by the slice condition block.
// Assumes: Three-bit condition codes.
// Notes: Codes follow the condition field encoding.
package slice_cond_pkg;
  typedef enum logic [2:0] {
    COND_HIGH = 3'h0,
    COND_STICKY_RISE = 3'h1,
    COND_STICKY_FALL = 3'h2,
    COND_STICKY_ANY = 3'h3,
    COND_LEVEL_HIGH = 3'h4,
    COND_LEVEL_LOW = 3'h5,
    COND_ZERO = 3'h6,
    COND_EVENT = 3'h7
  } cond_e;
endpackage

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the slice 5 and 6 match condition block.
// Assumes: Slice 5 watches pin 5 and slice 6 watches pin 6 once the source field is written.
// Notes: Slice 6 runs the mirrored code of slice 5 so that a swap of the slices shows.
`timescale 1ns/100ps
`include "slice_cond_regs.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

module testbench;
  // --------------------------------------------------------------------------
  // Design and stimulus
  // --------------------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0] pin_in = 8'h00;
  logic slice5_match;
  logic slice6_match;
  logic irq;
  int errors = 0;
  int comparisons = 0;
  logic [31:0] rdv;
  logic [31:0] cfgv;
  localparam logic [31:0] SRCV = 32'h001A8000;
  localparam logic [7:0] AFTER_BOTH = 8'h2F;

  always #5 sys_clk = ~sys_clk;

  pattern_match_slice_condition #(.NUM_INPUTS(8)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .slice5_match(slice5_match), .slice6_match(slice6_match), .irq(irq)
  );

  // --------------------------------------------------------------------------
  // Bus and check tasks
  // --------------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic settle();
    repeat (4) @(posedge sys_clk);
    #1;
  endtask

  // The event code adds a pulse only in the cycle where ev is set.
  task automatic chk_m(input logic [2:0] c, input logic [7:0] tab, input logic ev);
    `CHK(slice5_match, tab[c] | (ev & (c == 3'h7)))
    `CHK(slice6_match, tab[~c] | (ev & (c == 3'h0)))
  endtask

  // Pins change at edge k, the match must show after edge k+3, a pulse for one cycle only.
  task automatic pins(input logic v, input logic [2:0] c, input logic [7:0] tab);
    @(posedge sys_clk);
    pin_in <= {1'b0, v, v, 5'h00};
    repeat (3) @(posedge sys_clk);
    #1;
    chk_m(c, tab, 1'b1);
    @(posedge sys_clk);
    #1;
    chk_m(c, tab, 1'b0);
  endtask

  task automatic final_report();
    if (errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------------
  initial begin
    #200000;
    errors++;
    final_report();
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`REG_COND_CFG, rdv);
    `CHK(rdv, 32'h00000000)
    settle();
    `CHK({slice6_match, slice5_match, irq}, 3'h6)
    wr(`REG_SRC_SEL, SRCV);
    rd(`REG_SRC_SEL, rdv);
    `CHK(rdv, SRCV)
    for (int i = 0; i < 8; i++) begin
      cfgv = ({29'h0, 3'(i)} << 23) | ({29'h0, 3'(7 - i)} << 26);
      wr(`REG_COND_CFG, cfgv);
      rd(`REG_COND_CFG, rdv);
      `CHK(rdv, cfgv)
      settle();
      chk_m(3'(i), 8'h21, 1'b0);
      pins(1'b1, 3'(i), 8'h1B);
      pins(1'b0, 3'(i), 8'h2F);
      wr(`REG_IRQ_MASK, 32'h00000000);
      rd(`REG_IRQ_STATUS, rdv);
      settle();
      chk_m(3'(i), 8'h2F, 1'b0);
      rd(`REG_MATCH_STATE, rdv);
      `CHK(rdv, {24'h0, 6'h1B, AFTER_BOTH[3'(7 - i)], AFTER_BOTH[3'(i)]})
      if (i % 2 == 1) begin
        wr(`REG_SRC_SEL, SRCV);
      end else begin
        wr(`REG_COND_CFG, cfgv);
      end
      settle();
      chk_m(3'(i), 8'h21, 1'b0);
    end
    wr(`REG_IRQ_STATUS, 32'h00000003);
    wr(`REG_IRQ_MASK, 32'h00000001);
    wr(`REG_COND_CFG, 32'h18000000 | 32'h02000000);
    settle();
    rd(`REG_IRQ_STATUS, rdv);
    `CHK({rdv, irq}, 33'h0)
    @(posedge sys_clk);
    pin_in <= 8'h60;
    settle();
    `CHK(irq, 1'b1)
    rd(`REG_IRQ_STATUS, rdv);
    `CHK(rdv, 32'h00000001)
    wr(`REG_IRQ_MASK, 32'h00000000);
    settle();
    `CHK(irq, 1'b0)
    wr(`REG_IRQ_MASK, 32'h00000001);
    @(posedge sys_clk);
    pin_in <= 8'h00;
    settle();
    `CHK({irq, slice5_match}, 2'h2)
    wr(`REG_IRQ_STATUS, 32'h00000001);
    settle();
    rd(`REG_IRQ_STATUS, rdv);
    `CHK({rdv, irq}, 33'h0)
    wr(8'h20, 32'hFFFFFFFF);
    rd(8'h20, rdv);
    `CHK(rdv, 32'h00000000)
    rd(`REG_COND_CFG, rdv);
    `CHK(rdv, 32'h1A000000)
    final_report();
  end
endmodule
